// >>> inc/sram_crc_defines.svh
// constants for the background sram crc monitor
// Function
// - keep computing a 32-bit crc over code and calibration sram regions
// - after each region pass load its crc into the derived registers
// - after each full pass compare with signatures, set error bit 2
// - error bit is zero only while all four signature words matched at the last full pass, or before the first pass
// - calibration signature words readable at page 4, bytes 0x04 to 0x07
// - calibration derived words readable at page 4, bytes 0x08 to 0x0b
// - program signature words readable at page 4, bytes 0x0c to 0x0f
// - program derived words readable at page 4, bytes 0x10 to 0x13
// - lot serial word readable at page 4, bytes 0x20 and 0x21
`ifndef SRAM_CRC_DEFINES_SVH
`define SRAM_CRC_DEFINES_SVH

// ----------------------------------------------------------------------
// register page and byte offsets
// ----------------------------------------------------------------------
`define CRC_PAGE 8'h04
`define OFS_CALIB_SIG_LO 7'h04
`define OFS_CALIB_SIG_HI 7'h06
`define OFS_CALIB_DRV_LO 7'h08
`define OFS_CALIB_DRV_HI 7'h0a
`define OFS_PROG_SIG_LO 7'h0c
`define OFS_PROG_SIG_HI 7'h0e
`define OFS_PROG_DRV_LO 7'h10
`define OFS_PROG_DRV_HI 7'h12
`define OFS_LOT_ID 7'h20
`define OFS_PAIR_MASK 7'h7e

// ----------------------------------------------------------------------
// field positions and crc constants
// ----------------------------------------------------------------------
`define SYS_ERR_SRAM_BIT 2
`define CRC_INIT 32'hffffffff
`define CRC_FINAL_XOR 32'hffffffff
`define CRC_POLY 32'hedb88320
`define DERIVED_RESET 32'h00000000

// ----------------------------------------------------------------------
// sram region layout, 16-bit words
// ----------------------------------------------------------------------
`define PROG_BASE 12'h000
`define PROG_LAST 12'h7ff
`define CALIB_BASE 12'h800
`define CALIB_LAST 12'hfff

`endif

// >>> inc/sram_crc_pkg.sv
// types for the background sram crc monitor
`default_nettype none
package sram_crc_pkg;
    typedef enum logic [3:0] {
        ST_START = 4'h1,
        ST_ISSUE = 4'h2,
        ST_WAIT = 4'h4,
        ST_DONE = 4'h8
    } scan_state_type;
endpackage : sram_crc_pkg
`default_nettype wire

// >>> src/sram_crc_monitor.sv
// background crc scan of code and calibration sram with paged readback
`timescale 1ns/1ps
`default_nettype none
`include "sram_crc_defines.svh"

module sram_crc_monitor (
    input wire logic clk,
    input wire logic rstn,
    output logic mem_rd,
    output logic [11:0] mem_addr,
    input wire logic [15:0] mem_data,
    input wire logic [31:0] calib_signature,
    input wire logic [31:0] program_signature,
    input wire logic [15:0] lot_identifier_word,
    input wire logic rd_en,
    input wire logic [7:0] rd_page,
    input wire logic [6:0] rd_addr,
    output logic [15:0] rd_data,
    output logic rd_valid,
    output logic sram_integrity_error,
    output logic pass_done
);

    // ------------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------------
    logic rst_meta_ff;
    logic rst_sync_ff;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end
    wire logic rst_n = rst_sync_ff;

    // ------------------------------------------------------------------
    // crc arithmetic
    // ------------------------------------------------------------------
    function automatic logic [31:0] crc_byte(input logic [31:0] crc,
                                             input logic [7:0] data);
        logic [31:0] c;
        c = crc ^ {24'h000000, data};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ `CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction : crc_byte

    // ------------------------------------------------------------------
    // scan state
    // ------------------------------------------------------------------
    sram_crc_pkg::scan_state_type state_ff;
    sram_crc_pkg::scan_state_type nxt_state;
    logic region_ff; // 0 program, 1 calibration
    logic [11:0] addr_ff;
    logic [31:0] crc_ff;
    logic [31:0] calib_derived_ff;
    logic [31:0] program_derived_ff;
    logic first_done_ff;
    logic err_ff;
    logic mem_rd_ff;
    logic pass_done_ff;
    logic [15:0] rd_data_ff;
    logic rd_valid_ff;

    // low byte first, then high byte of each word
    wire logic [31:0] crc_word =
        crc_byte(crc_byte(crc_ff, mem_data[7:0]), mem_data[15:8]);
    wire logic [31:0] crc_final = crc_ff ^ `CRC_FINAL_XOR;
    wire logic region_last = region_ff ? (addr_ff == `CALIB_LAST)
                                       : (addr_ff == `PROG_LAST);
    wire logic [11:0] region_base = region_ff ? `CALIB_BASE : `PROG_BASE;
    wire logic in_done = (state_ff == sram_crc_pkg::ST_DONE);
    wire logic calib_end = in_done && region_ff;
    wire logic prog_end = in_done && !region_ff;
    // compare calibration against the value being loaded so no stale word is used
    wire logic mismatch = (crc_final != calib_signature)
                       || (program_derived_ff != program_signature);

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            sram_crc_pkg::ST_START: nxt_state = sram_crc_pkg::ST_ISSUE;
            sram_crc_pkg::ST_ISSUE: nxt_state = sram_crc_pkg::ST_WAIT;
            sram_crc_pkg::ST_WAIT: nxt_state = region_last ?
                sram_crc_pkg::ST_DONE : sram_crc_pkg::ST_ISSUE;
            sram_crc_pkg::ST_DONE: nxt_state = sram_crc_pkg::ST_START;
            default: nxt_state = sram_crc_pkg::ST_START;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= sram_crc_pkg::ST_START;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // wait state captures the word while the strobe is high, at the edge that ends it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_ff <= `PROG_BASE;
            crc_ff <= `CRC_INIT;
            region_ff <= 1'b0;
            mem_rd_ff <= 1'b0;
        end else begin
            mem_rd_ff <= (state_ff == sram_crc_pkg::ST_ISSUE);
            if (state_ff == sram_crc_pkg::ST_START) begin
                addr_ff <= region_base;
                crc_ff <= `CRC_INIT;
            end
            if (state_ff == sram_crc_pkg::ST_WAIT) begin
                crc_ff <= crc_word;
                if (!region_last) begin
                    addr_ff <= addr_ff + 12'h001;
                end
            end
            if (in_done) begin
                region_ff <= !region_ff;
            end
        end
    end

    // ------------------------------------------------------------------
    // derived values and error flag
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            calib_derived_ff <= `DERIVED_RESET;
            program_derived_ff <= `DERIVED_RESET;
            first_done_ff <= 1'b0;
            err_ff <= 1'b0;
            pass_done_ff <= 1'b0;
        end else begin
            pass_done_ff <= calib_end;
            if (prog_end) begin
                program_derived_ff <= crc_final;
            end
            if (calib_end) begin
                calib_derived_ff <= crc_final;
                first_done_ff <= 1'b1;
                err_ff <= mismatch;
            end
        end
    end

    // ------------------------------------------------------------------
    // paged register readback
    // ------------------------------------------------------------------
    wire logic on_page = (rd_page == `CRC_PAGE);
    wire logic [6:0] pair = rd_addr & `OFS_PAIR_MASK;
    logic [15:0] rd_mux;
    always_comb begin
        rd_mux = 16'h0000;
        if (on_page) begin
            case (pair)
                `OFS_CALIB_SIG_LO: rd_mux = calib_signature[15:0];
                `OFS_CALIB_SIG_HI: rd_mux = calib_signature[31:16];
                `OFS_CALIB_DRV_LO: rd_mux = calib_derived_ff[15:0];
                `OFS_CALIB_DRV_HI: rd_mux = calib_derived_ff[31:16];
                `OFS_PROG_SIG_LO: rd_mux = program_signature[15:0];
                `OFS_PROG_SIG_HI: rd_mux = program_signature[31:16];
                `OFS_PROG_DRV_LO: rd_mux = program_derived_ff[15:0];
                `OFS_PROG_DRV_HI:
                    rd_mux = program_derived_ff[31:16];
                `OFS_LOT_ID: rd_mux = lot_identifier_word;
                default: rd_mux = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_ff <= 16'h0000;
            rd_valid_ff <= 1'b0;
        end else begin
            rd_valid_ff <= rd_en;
            if (rd_en) begin
                rd_data_ff <= rd_mux;
            end
        end
    end

    assign mem_rd = mem_rd_ff;
    assign mem_addr = addr_ff;
    assign rd_data = rd_data_ff;
    assign rd_valid = rd_valid_ff;
    assign sram_integrity_error = err_ff;
    assign pass_done = pass_done_ff;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    wire logic rd4 = rd_en && on_page;
    sequence fetch_s;
        (state_ff == sram_crc_pkg::ST_ISSUE) ##1 mem_rd_ff ##1 !mem_rd_ff;
    endsequence
    sequence load_s;
        prog_end ##1 (program_derived_ff == $past(crc_final));
    endsequence

    fetch_cycle_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (state_ff == sram_crc_pkg::ST_ISSUE) |-> fetch_s)
        else $error("sram fetch strobe malformed");
    prog_load_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        prog_end |-> load_s)
        else $error("program derived not loaded");
    calib_load_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        calib_end |=> calib_derived_ff == $past(crc_final) && pass_done_ff)
        else $error("calibration derived not loaded");
    err_compare_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        calib_end |=> err_ff == $past(mismatch))
        else $error("error flag not set from compare");
    err_stable_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        !calib_end |=> $stable(err_ff))
        else $error("error flag moved outside pass end");
    err_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        pass_done_ff && calib_derived_ff == calib_signature
        && program_derived_ff == program_signature |-> !err_ff)
        else $error("error flag set while all match");
    first_zero_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        !first_done_ff |-> !err_ff && calib_derived_ff == 32'h00000000)
        else $error("values changed before first pass");
    calib_sig_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        rd4 && rd_addr == `OFS_CALIB_SIG_HI
        |=> rd_valid_ff && rd_data_ff == $past(calib_signature[31:16]))
        else $error("calibration signature high readback wrong");
    calib_drv_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        rd4 && rd_addr == `OFS_CALIB_DRV_LO
        |=> rd_data_ff == $past(calib_derived_ff[15:0]))
        else $error("calibration derived low readback wrong");
    prog_sig_a: assert property (@(posedge clk) disable iff (!rst_n)
        rd4 && rd_addr == `OFS_PROG_SIG_LO
        |=> rd_data_ff == $past(program_signature[15:0]))
        else $error("program signature low readback wrong");
    prog_drv_a: assert property (@(posedge clk) disable iff (!rst_n)
        rd4 && rd_addr == `OFS_PROG_DRV_HI
        |=> rd_data_ff == $past(program_derived_ff[31:16]))
        else $error("program derived high readback wrong");
    lot_id_a: assert property (@(posedge clk) disable iff (!rst_n)
        rd4 && pair == `OFS_LOT_ID
        |=> rd_data_ff == $past(lot_identifier_word))
        else $error("lot serial readback wrong");

endmodule : sram_crc_monitor
`default_nettype wire

// >>> test/sram_crc_monitor_tb_top.sv
// self-checking bench for the background sram crc monitor
`timescale 1ns/1ps
`default_nettype none
`include "sram_crc_defines.svh"

module sram_crc_monitor_tb_top;
    logic clk, rstn, mem_rd, rd_en, rd_valid, err, pass_done;
    logic [11:0] mem_addr;
    logic [15:0] mem_data, lot, rd_data;
    logic [31:0] cal_sig, prog_sig, exp_cal, exp_prog;
    logic [7:0] rd_page;
    logic [6:0] rd_addr;
    int n_mismatch, n_tests;

    sram_crc_monitor sram_crc_monitor_i (.clk(clk), .rstn(rstn),
        .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_data(mem_data),
        .calib_signature(cal_sig), .program_signature(prog_sig),
        .lot_identifier_word(lot), .rd_en(rd_en), .rd_page(rd_page),
        .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid),
        .sram_integrity_error(err), .pass_done(pass_done));
    sram_word_model sram_word_model_i (.clk(clk), .mem_rd(mem_rd),
        .mem_addr(mem_addr), .mem_data(mem_data));

    // ------------------------------------------------------------------
    // reference and access tasks
    // ------------------------------------------------------------------
    // bitwise reflected crc, low byte first, lsb first within a byte
    function automatic logic [31:0] region_crc(int first, int last);
        logic [31:0] c;
        logic [15:0] w;
        c = `CRC_INIT;
        for (int a = first; a <= last; a++) begin
            w = sram_word_model_i.mem[a];
            for (int b = 0; b < 16; b++) begin
                c = (c[0] ^ w[b]) ? ((c >> 1) ^ `CRC_POLY) : (c >> 1);
            end
        end
        return c ^ `CRC_FINAL_XOR;
    endfunction : region_crc

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report

    task automatic rd(input logic [7:0] page, input logic [6:0] addr,
                      input logic [15:0] exp);
        @(posedge clk);
        rd_en <= 1'b1;
        rd_page <= page;
        rd_addr <= addr;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        check({15'h0000, rd_valid}, 16'h0001);
        check(rd_data, exp);
    endtask : rd

    task automatic wait_pass();
        int k;
        k = 0;
        do begin
            @(posedge clk);
            #1;
            k++;
        end while (pass_done !== 1'b1 && k < 20000);
        if (pass_done !== 1'b1) begin
            n_mismatch++;
            final_report();
        end
    endtask : wait_pass

    // odd byte offsets on purpose: both bytes of a pair name one word
    task automatic read_all(input logic [31:0] cd, input logic [31:0] pd);
        rd(`CRC_PAGE, 7'h05, cal_sig[15:0]);
        rd(`CRC_PAGE, 7'h06, cal_sig[31:16]);
        rd(`CRC_PAGE, 7'h08, cd[15:0]);
        rd(`CRC_PAGE, 7'h0b, cd[31:16]);
        rd(`CRC_PAGE, 7'h0c, prog_sig[15:0]);
        rd(`CRC_PAGE, 7'h0f, prog_sig[31:16]);
        rd(`CRC_PAGE, 7'h11, pd[15:0]);
        rd(`CRC_PAGE, 7'h12, pd[31:16]);
        rd(`CRC_PAGE, 7'h21, lot);
        rd(8'h03, 7'h08, 16'h0000);
        rd(`CRC_PAGE, 7'h14, 16'h0000);
    endtask : read_all

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        rstn = 1'b0;
        rd_en = 1'b0;
        rd_page = 8'h00;
        rd_addr = 7'h00;
        lot = 16'h6b2d;
        cal_sig = 32'h00000000;
        prog_sig = 32'h00000000;
        n_mismatch = 0;
        n_tests = 0;
        repeat (4) @(posedge clk);
        exp_cal = region_crc(`CALIB_BASE, `CALIB_LAST);
        exp_prog = region_crc(`PROG_BASE, `PROG_LAST);
        rstn <= 1'b1;
        cal_sig <= exp_cal;
        prog_sig <= ~exp_prog;
        repeat (4) @(posedge clk);
        read_all(32'h00000000, 32'h00000000);
        check({15'h0000, err}, 16'h0000);
        wait_pass();
        check({15'h0000, err}, 16'h0001);
        read_all(exp_cal, exp_prog);
        @(posedge clk);
        prog_sig <= exp_prog;
        wait_pass();
        check({15'h0000, err}, 16'h0000);
        @(posedge clk);
        cal_sig <= exp_cal ^ 32'h00010000;
        wait_pass();
        check({15'h0000, err}, 16'h0001);
        read_all(exp_cal, exp_prog);
        final_report();
    end
endmodule : sram_crc_monitor_tb_top
`default_nettype wire

// >>> test/sram_word_model.sv
// sram word store answering the monitor's one-cycle fetches
`timescale 1ns/1ps
`default_nettype none

module sram_word_model (
    input wire logic clk,
    input wire logic mem_rd,
    input wire logic [11:0] mem_addr,
    output logic [15:0] mem_data
);
    logic [15:0] mem [0:4095];
    logic [15:0] churn_ff;
    initial begin
        churn_ff = 16'h0000;
        for (int i = 0; i < 4096; i++) begin
            mem[i] = {i[3:0], i[11:0]} ^ 16'h3c5a;
        end
    end
    // the monitor samples at the edge that ends its strobe, so the word
    // must stand while the strobe is high; it churns otherwise
    always @(posedge clk) begin
        churn_ff <= ~churn_ff;
    end
    assign mem_data = mem_rd ? mem[mem_addr] : churn_ff;
endmodule : sram_word_model
`default_nettype wire
